/* File: rtl/rph_port.sv */
/*
  Status and control logic for one downstream root hub port.
  Assumes a single 10 MHz clock with synchronous active-high reset; line
  inputs from the device arrive asynchronously, babble is synchronous.
*/
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps

module rph_port
  import rph_pkg::*;
#(
  parameter int RESET_CYC = RPH_RESET_CYC,
  parameter int RESUME_CYC = RPH_RESUME_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire rph_bus_req_t bus,
  output logic [31:0] rdata,
  // Controller and device side.
  input wire logic controller_resume_state,
  input wire rph_line_t line,
  // Port signalling.
  output logic port_reset_drive,
  output logic port_resume_drive,
  output logic port_power_drive
);

  initial begin
    if (RESET_CYC < 1 || RESUME_CYC < 1 || RESET_CYC >= 2 ** 24 ||
        RESUME_CYC >= 2 ** 24) begin
      $error("rph_port: interval counts out of range");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_RESUME} rph_seq_t;

  // ==========================================================
  // Input synchronisers.
  logic [2:0] conn_sync;
  logic [2:0] slow_sync;
  logic [2:0] ovc_sync;
  logic conn_line;
  logic slow_line;
  logic ovc_line;

  always_ff @(posedge clk) begin
    if (rst) begin
      conn_sync <= 3'h0;
      slow_sync <= 3'h0;
      ovc_sync <= 3'h0;
    end else begin
      conn_sync <= {conn_sync[1:0], line.connect};
      slow_sync <= {slow_sync[1:0], line.slow};
      ovc_sync <= {ovc_sync[1:0], line.overcurrent};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conn_line <= 1'b0;
      slow_line <= 1'b0;
      ovc_line <= 1'b0;
    end else begin
      if (conn_sync[2] == conn_sync[1]) begin
        conn_line <= conn_sync[1];
      end
      if (slow_sync[2] == slow_sync[1]) begin
        slow_line <= slow_sync[1];
      end
      if (ovc_sync[2] == ovc_sync[1]) begin
        ovc_line <= ovc_sync[1];
      end
    end
  end

  // ==========================================================
  // Configuration register.
  logic [4:0] cfg;
  logic wr_stat;
  logic wr_cfg;
  logic wr_glob;

  assign wr_stat = bus.wr && bus.addr == RPH_STATUS_ADDR;
  assign wr_cfg = bus.wr && bus.addr == RPH_CONFIG_ADDR;
  assign wr_glob = bus.wr && bus.addr == RPH_GLOBAL_ADDR;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= RPH_CONFIG_RESET;
    end else if (wr_cfg) begin
      cfg <= bus.wdata[4:0];
    end
  end

  // ==========================================================
  // State.
  logic port_powered;
  logic device_connected;
  logic port_enabled;
  logic port_suspended;
  logic port_resetting;
  logic port_overcurrent;
  logic connect_change_flag;
  logic enable_change_flag;
  logic resume_done_flag;
  logic overcurrent_change_flag;
  logic reset_done_flag;
  logic fixed_device_mask;
  logic conn_now;
  logic conn_prev;
  logic fixed_report;
  logic reset_end;
  logic resume_end;
  logic power_off_ev;
  logic hw_disable;
  logic connect_cmd_miss;
  logic power_on_cmd;
  logic power_off_cmd;
  rph_seq_t seq;
  logic [23:0] timer;

  assign fixed_device_mask = cfg[RPH_C_FIXED];
  assign conn_now = fixed_device_mask ? 1'b1 : (conn_line && port_powered);
  assign port_overcurrent = cfg[RPH_C_OVC_PORT] & ovc_line;

  always_comb begin
    power_on_cmd = 1'b0;
    power_off_cmd = 1'b0;
    if (!cfg[RPH_C_SCHEME] || !cfg[RPH_C_MASK]) begin
      power_on_cmd = wr_glob && bus.wdata[RPH_G_ON];
      power_off_cmd = wr_glob && bus.wdata[RPH_G_OFF];
    end else begin
      power_on_cmd = wr_stat && bus.wdata[RPH_B_PWR];
      power_off_cmd = wr_stat && bus.wdata[RPH_B_SLOW];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_powered <= RPH_PWR_RESET;
    end else if (cfg[RPH_C_NO_SWITCH]) begin
      port_powered <= 1'b1;
    end else if (port_overcurrent) begin
      port_powered <= 1'b0;
    end else if (power_off_cmd) begin
      port_powered <= 1'b0;
    end else if (power_on_cmd) begin
      port_powered <= 1'b1;
    end
  end

  assign power_off_ev = !port_powered;

  always_ff @(posedge clk) begin
    if (rst) begin
      device_connected <= 1'b0;
      conn_prev <= 1'b0;
    end else begin
      device_connected <= conn_now;
      conn_prev <= device_connected;
    end
  end

  assign connect_cmd_miss = wr_stat && !device_connected &&
    (bus.wdata[RPH_B_RST] || bus.wdata[RPH_B_ENA] || bus.wdata[RPH_B_SUSP]);

  // ==========================================================
  // Reset and resume sequencer.
  // A sequence completes only on a port that is still powered and connected.
  assign reset_end = seq == ST_RESET && timer == 24'h0000_00 &&
    port_resetting && device_connected && port_powered;
  assign resume_end = seq == ST_RESUME && timer == 24'h0000_00 &&
    device_connected && port_powered;

  always_ff @(posedge clk) begin
    if (rst) begin
      seq <= ST_IDLE;
      timer <= 24'h0000_00;
    end else if (power_off_ev || !device_connected) begin
      seq <= ST_IDLE;
      timer <= 24'h0000_00;
    end else begin
      unique case (seq)
        ST_IDLE: begin
          if (wr_stat && bus.wdata[RPH_B_RST]) begin
            seq <= ST_RESET;
            timer <= 24'(RESET_CYC - 1);
          end else if (wr_stat && bus.wdata[RPH_B_OVC] && port_suspended) begin
            seq <= ST_RESUME;
            timer <= 24'(RESUME_CYC - 1);
          end
        end
        ST_RESET, ST_RESUME: begin
          if (timer == 24'h0000_00) begin
            seq <= ST_IDLE;
          end else begin
            timer <= timer - 24'h0000_01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_resetting <= 1'b0;
    end else if (power_off_ev || !device_connected || reset_end) begin
      port_resetting <= 1'b0;
    end else if (wr_stat && bus.wdata[RPH_B_RST] && seq == ST_IDLE) begin
      port_resetting <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_suspended <= 1'b0;
    end else if (power_off_ev || !device_connected || reset_end ||
                 resume_end || controller_resume_state) begin
      port_suspended <= 1'b0;
    end else if (wr_stat && bus.wdata[RPH_B_SUSP]) begin
      port_suspended <= 1'b1;
    end
  end

  assign hw_disable = port_enabled && (port_overcurrent || power_off_ev ||
    !device_connected || line.babble);

  always_ff @(posedge clk) begin
    if (rst) begin
      port_enabled <= 1'b0;
    end else if (hw_disable) begin
      port_enabled <= 1'b0;
    end else if (wr_stat && bus.wdata[RPH_B_CONN]) begin
      port_enabled <= 1'b0;
    end else if (reset_end || resume_end) begin
      port_enabled <= 1'b1;
    end else if (wr_stat && bus.wdata[RPH_B_ENA] && device_connected) begin
      port_enabled <= 1'b1;
    end
  end

  // ==========================================================
  // Change flags; a set in the same cycle beats the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      fixed_report <= 1'b1;
    end else if (fixed_device_mask) begin
      // The pending report is spent once a fixed device is declared.
      fixed_report <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      connect_change_flag <= 1'b0;
    end else if ((!fixed_device_mask && device_connected != conn_prev) ||
                 (fixed_device_mask && fixed_report) || connect_cmd_miss) begin
      connect_change_flag <= 1'b1;
    end else if (wr_stat && bus.wdata[RPH_B_CONN_CHG]) begin
      connect_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_change_flag <= 1'b0;
    end else if (hw_disable) begin
      enable_change_flag <= 1'b1;
    end else if (wr_stat && bus.wdata[RPH_B_ENA_CHG]) begin
      enable_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resume_done_flag <= 1'b0;
    end else if (reset_end) begin
      resume_done_flag <= 1'b0;
    end else if (resume_end) begin
      resume_done_flag <= 1'b1;
    end else if (wr_stat && bus.wdata[RPH_B_RES_DONE]) begin
      resume_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_done_flag <= 1'b0;
    end else if (reset_end) begin
      reset_done_flag <= 1'b1;
    end else if (wr_stat && bus.wdata[RPH_B_RST_DONE]) begin
      reset_done_flag <= 1'b0;
    end
  end

  logic ovc_prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      ovc_prev <= 1'b0;
      overcurrent_change_flag <= 1'b0;
    end else begin
      ovc_prev <= port_overcurrent;
      if (ovc_prev != port_overcurrent) begin
        overcurrent_change_flag <= 1'b1;
      end else if (wr_stat && bus.wdata[RPH_B_OVC_CHG]) begin
        overcurrent_change_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read data.
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.addr == RPH_STATUS_ADDR) begin
      next_rdata[RPH_B_CONN] = device_connected;
      next_rdata[RPH_B_ENA] = port_enabled;
      next_rdata[RPH_B_SUSP] = port_suspended;
      next_rdata[RPH_B_OVC] = port_overcurrent;
      next_rdata[RPH_B_RST] = port_resetting;
      next_rdata[RPH_B_PWR] = port_powered;
      next_rdata[RPH_B_SLOW] = slow_line && device_connected;
      next_rdata[RPH_B_CONN_CHG] = connect_change_flag;
      next_rdata[RPH_B_ENA_CHG] = enable_change_flag;
      next_rdata[RPH_B_RES_DONE] = resume_done_flag;
      next_rdata[RPH_B_OVC_CHG] = overcurrent_change_flag;
      next_rdata[RPH_B_RST_DONE] = reset_done_flag;
    end else if (bus.addr == RPH_CONFIG_ADDR) begin
      next_rdata[4:0] = cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign port_reset_drive = port_resetting;
  assign port_resume_drive = seq == ST_RESUME;
  assign port_power_drive = port_powered;

  // ==========================================================
  // Checks.
  // no status without connect.
  no_stat_disc_a: assert property (@(posedge clk) disable iff (rst)
    !device_connected |-> ##1 !$rose(port_resetting) && !$rose(port_enabled))
    else $error("status set while disconnected");

  res_clr_rst_a: assert property (@(posedge clk) disable iff (rst)
    reset_end |=> !resume_done_flag && reset_done_flag)
    else $error("resume flag survived reset done");

  rst_stat_end_a: assert property (@(posedge clk) disable iff (rst)
    $rose(reset_done_flag) |-> !port_resetting)
    else $error("reset status held after done");

  ena_on_done_a: assert property (@(posedge clk) disable iff (rst)
    reset_end && !hw_disable |=> port_enabled)
    else $error("port not enabled after reset");

  chg_keep_a: assert property (@(posedge clk) disable iff (rst)
    wr_stat && !bus.wdata[RPH_B_ENA_CHG] && enable_change_flag |=>
    enable_change_flag)
    else $error("change flag lost on zero write");

  ena_sw_a: assert property (@(posedge clk) disable iff (rst)
    $rose(enable_change_flag) |-> $past(hw_disable))
    else $error("enable change without hardware event");

  miss_flag_a: assert property (@(posedge clk) disable iff (rst)
    connect_cmd_miss |=> connect_change_flag && !port_resetting)
    else $error("disconnected command not flagged");

  ovc_pwr_a: assert property (@(posedge clk) disable iff (rst)
    port_overcurrent && !cfg[RPH_C_NO_SWITCH] |=> !port_powered)
    else $error("power kept under overcurrent");

endmodule : rph_port

/* File: rtl/rph_pkg.sv */
/*
  Package for the root hub port status block: register layout, reset
  values, timing constants and carrier structs.
  Assumes a 10 MHz controller clock.
*/
package rph_pkg;

  // ==========================================================
  // Register map.
  localparam logic [7:0] RPH_STATUS_ADDR = 8'h00;
  localparam logic [7:0] RPH_CONFIG_ADDR = 8'h04;
  localparam logic [7:0] RPH_GLOBAL_ADDR = 8'h08;

  // ==========================================================
  // Port status bit positions.
  localparam int RPH_B_CONN = 0;
  localparam int RPH_B_ENA = 1;
  localparam int RPH_B_SUSP = 2;
  localparam int RPH_B_OVC = 3;
  localparam int RPH_B_RST = 4;
  localparam int RPH_B_PWR = 8;
  localparam int RPH_B_SLOW = 9;
  localparam int RPH_B_CONN_CHG = 16;
  localparam int RPH_B_ENA_CHG = 17;
  localparam int RPH_B_RES_DONE = 18;
  localparam int RPH_B_OVC_CHG = 19;
  localparam int RPH_B_RST_DONE = 20;

  // Config register bit positions.
  localparam int RPH_C_NO_SWITCH = 0;
  localparam int RPH_C_SCHEME = 1;
  localparam int RPH_C_MASK = 2;
  localparam int RPH_C_FIXED = 3;
  localparam int RPH_C_OVC_PORT = 4;

  // Global power command bit positions.
  localparam int RPH_G_OFF = 0;
  localparam int RPH_G_ON = 16;

  // ==========================================================
  // Reset values.
  localparam logic RPH_PWR_RESET = 1'h1;
  localparam logic [4:0] RPH_CONFIG_RESET = 5'h10;

  // ==========================================================
  // Timing.
  localparam int RPH_CLK_HZ = 10_000_000;
  localparam int RPH_RESET_MS = 10;
  localparam int RPH_RESUME_MS = 20;
  localparam int RPH_EOP_US = 2;
  localparam int RPH_RESYNC_MS = 3;
  localparam int RPH_RESET_CYC = RPH_RESET_MS * (RPH_CLK_HZ / 1000);
  localparam int RPH_RESUME_CYC = RPH_RESUME_MS * (RPH_CLK_HZ / 1000)
    + RPH_EOP_US * (RPH_CLK_HZ / 1_000_000)
    + RPH_RESYNC_MS * (RPH_CLK_HZ / 1000);

  // ==========================================================
  // Carriers.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rph_bus_req_t;

  typedef struct packed {
    logic connect;
    logic slow;
    logic overcurrent;
    logic babble;
  } rph_line_t;

endpackage : rph_pkg

/* File: sim/rph_dev_model.sv */
/*
  Behavioural model of the USB device plugged into the downstream port.
  Assumes the bench steers plug, speed, fault and babble requests on the
  rising clock edge.
*/
`timescale 1ns/100ps

module rph_dev_model
  import rph_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Requests from the bench.
  input wire logic plug,
  input wire logic slow_req,
  input wire logic oc_req,
  input wire logic babble_req,
  // Line towards the port.
  output rph_line_t line
);
  logic babble_d;

  // ==========================================================
  // Line levels.
  // Speed is only signalled while a device is plugged in.
  always_ff @(posedge clk) begin
    babble_d <= babble_req;
  end
  assign line.connect = plug;
  assign line.slow = plug & slow_req;
  assign line.overcurrent = oc_req;
  assign line.babble = babble_req & ~babble_d;
endmodule : rph_dev_model

/* File: sim/usb_root_hub_port_status_bench.sv */
/*
  Self-checking bench for one root hub port.
  Assumes the port module, its package and the device model are compiled
  first; runs shortened reset and resume intervals.
*/
`timescale 1ns/100ps

module usb_root_hub_port_status_bench;
  import rph_pkg::*;
  localparam int RST_CYC = 20;
  localparam int RES_CYC = 30;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [7:0] ST = RPH_STATUS_ADDR;
  localparam logic [7:0] CF = RPH_CONFIG_ADDR;
  localparam logic [7:0] GL = RPH_GLOBAL_ADDR;
  localparam int P_RST = 0;
  localparam int P_RES = 1;
  localparam int P_PWR = 2;
  logic clk, rst, ctl_resume, plug, slow_req, oc_req, babble_req;
  logic rst_drv, res_drv, pwr_drv, rd_seen;
  logic [31:0] rdata;
  rph_bus_req_t bus;
  rph_line_t line;
  int err_count, cmp_count;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  rph_port #(.RESET_CYC(RST_CYC), .RESUME_CYC(RES_CYC)) dut (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .controller_resume_state(ctl_resume), .line(line),
    .port_reset_drive(rst_drv), .port_resume_drive(res_drv),
    .port_power_drive(pwr_drv));
  rph_dev_model dev (.clk(clk), .plug(plug), .slow_req(slow_req),
    .oc_req(oc_req), .babble_req(babble_req), .line(line));

  // ==========================================================
  // Clock and watchdog.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 20000);
    err_count++;
    end_of_test();
  end

  // ==========================================================
  // Tasks.
  task automatic end_of_test;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic cmp_reg(input logic [31:0] got, e, m);
    cmp_count++;
    if ((got & m) !== (e & m)) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got & m, e & m);
    end
  endtask : cmp_reg

  task automatic cmp_bit(input int sel, input logic e);
    logic got;
    @(negedge clk);
    got = sel == P_RST ? rst_drv : (sel == P_RES ? res_drv : pwr_drv);
    cmp_count++;
    if (got !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : cmp_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b0};
  endtask : rd

  task automatic st(input logic [31:0] e, m);
    rd(ST, e, m);
  endtask : st

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // ==========================================================
  // Read data monitor.
  always @(negedge clk) begin
    if (rd_seen) begin
      cmp_reg(rdata, exp_q.pop_front(), msk_q.pop_front());
    end
    rd_seen = bus.rd;
  end

  // ==========================================================
  // Main sequence.
  initial begin
    rst = 1'b1;
    bus = '0;
    {ctl_resume, plug, slow_req, oc_req, babble_req} = 5'h00;
    void'($urandom(32'ha8d2_cba0));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wt(8);
    st(32'h0000_0100, ALL);
    rd(CF, 32'h0000_0010, ALL);
    rd(8'h0c, 32'h0000_0000, ALL);
    for (int i = 1; i < 5; i++) begin
      if (i != 3) begin
        wr(ST, 32'h0000_0001 << i);
        st(32'h0001_0100, ALL);
        wr(ST, 32'h0000_0000);
        st(32'h0001_0100, ALL);
        wr(ST, 32'h0001_0000);
      end
    end
    plug <= 1'b1;
    wt(10);
    st(32'h0001_0101, ALL);
    wr(ST, 32'h0001_0000);
    wr(ST, 32'h0000_0010);
    st(32'h0000_0111, ALL);
    cmp_bit(P_RST, 1'b1);
    wt(RST_CYC + 4);
    st(32'h0010_0103, ALL);
    cmp_bit(P_RST, 1'b0);
    wr(ST, 32'h0010_0000);
    wr(ST, 32'h0000_0001);
    st(32'h0000_0101, ALL);
    wr(ST, 32'h0000_0008);
    st(32'h0000_0101, ALL);
    cmp_bit(P_RES, 1'b0);
    wr(ST, 32'h0000_0002);
    wr(ST, 32'h0000_0004);
    st(32'h0000_0107, ALL);
    wr(ST, 32'h0000_0008);
    cmp_bit(P_RES, 1'b1);
    wt(RES_CYC - 12);
    st(32'h0000_0004, 32'h0004_0004);
    wt(14);
    st(32'h0004_0103, ALL);
    cmp_bit(P_RES, 1'b0);
    wr(ST, 32'h0000_0010);
    wt(RST_CYC + 4);
    st(32'h0010_0103, ALL);
    wr(ST, 32'h0010_0000);
    wr(ST, 32'h0000_0004);
    ctl_resume <= 1'b1;
    wt(2);
    ctl_resume <= 1'b0;
    st(32'h0000_0103, ALL);
    babble_req <= 1'b1;
    wt(2);
    babble_req <= 1'b0;
    wt(2);
    st(32'h0002_0101, ALL);
    wr(ST, 32'h0002_0000);
    slow_req <= 1'b1;
    wt(10);
    st(32'h0000_0301, ALL);
    slow_req <= 1'b0;
    wt(10);
    wr(8'h0c, $urandom());
    st(32'h0000_0101, ALL);
    wr(ST, 32'h0000_0200);
    st(32'h0000_0100, 32'h0000_0100);
    wr(GL, 32'h0000_0001);
    st(32'h0000_0000, 32'h0000_0103);
    wr(GL, 32'h0001_0000);
    st(32'h0000_0100, 32'h0000_0100);
    cmp_bit(P_PWR, 1'b1);
    wr(CF, 32'h0000_0016);
    wr(GL, 32'h0000_0001);
    st(32'h0000_0100, 32'h0000_0100);
    wr(ST, 32'h0000_0200);
    cmp_bit(P_PWR, 1'b0);
    wr(ST, 32'h0000_0100);
    st(32'h0000_0100, 32'h0000_0100);
    wt(10);
    wr(ST, 32'h001f_0000);
    wr(ST, 32'h0000_0002);
    oc_req <= 1'b1;
    wt(10);
    st(32'h0002_0008, 32'h0002_010b);
    oc_req <= 1'b0;
    wt(10);
    wr(ST, 32'h0000_0100);
    wt(10);
    wr(ST, 32'h001f_0000);
    wr(ST, 32'h0000_0002);
    plug <= 1'b0;
    wt(10);
    st(32'h0003_0000, 32'h0003_0003);
    wr(CF, 32'h0000_0006);
    oc_req <= 1'b1;
    wt(10);
    st(32'h0000_0000, 32'h0000_0008);
    oc_req <= 1'b0;
    wr(CF, 32'h0000_0017);
    wr(ST, 32'h0000_0200);
    st(32'h0000_0100, 32'h0000_0100);
    wr(ST, 32'h001f_0000);
    wr(CF, 32'h0000_001e);
    wt(10);
    st(32'h0001_0001, 32'h0001_0001);
    wr(ST, 32'h0001_0000);
    wt(10);
    st(32'h0000_0001, 32'h0001_0001);
    wt(4);
    end_of_test();
  end
endmodule : usb_root_hub_port_status_bench
